// ---- hdl/interrupt_mask_and_instr_pointer.v ----
// Interrupt level enable register and 16-bit instruction pointer with register access.
`timescale 1ns/1ps
`default_nettype none
`include "intmask_ip_defines.vh"

// Contract
// [RL1] One enable bit per level n; 1 unmasks, 0 masks that level.
// [RL2] A masked level's request never reaches the CPU core.
// [RL3] High pointer register holds pointer bits 15 to 8, byte read/write.
// [RL4] Low pointer register holds pointer bits 7 to 0, byte read/write.
// [RL5] These registers are reached by direct register addressing only.
// [RL6] Software writes all bits after reset before relying on them.
module interrupt_mask_and_instr_pointer (
    input wire clock,
    input wire rst,
    input wire clock_enable,
    input wire [7:0] reg_address,
    input wire reg_direct_mode,
    input wire reg_write,
    input wire reg_read,
    input wire [7:0] reg_write_data,
    input wire ip_load,
    input wire [15:0] ip_load_value,
    input wire [7:0] interrupt_level_request,
    output reg [7:0] reg_read_data,
    output reg reg_read_hit,
    output reg [7:0] interrupt_level_enable,
    output reg [15:0] instruction_pointer,
    output reg [7:0] recognised_request
);

    reg [7:0] request_meta;
    reg [7:0] request_sync;

    // Only a direct register access may touch these locations.
    function hit;
        input [7:0] address;
        input [7:0] target;
        input direct;
        begin
            hit = direct && (address == target); // RL5
        end
    endfunction

    wire write_enable =
        hit(reg_address, `ADDR_INTERRUPT_LEVEL_ENABLE, reg_direct_mode) && reg_write;
    wire write_high =
        hit(reg_address, `ADDR_INSTR_POINTER_HIGH_BYTE, reg_direct_mode) && reg_write;
    wire write_low = hit(reg_address, `ADDR_INSTR_POINTER_LOW_BYTE, reg_direct_mode) && reg_write;

    reg [7:0] next_read_data;
    reg next_read_hit;

    always @* begin
        next_read_data = `BYTE_ZERO;
        next_read_hit = 1'b0;
        if (reg_read && reg_direct_mode) begin // RL5
            case (reg_address)
                `ADDR_INTERRUPT_LEVEL_ENABLE: begin
                    next_read_data = interrupt_level_enable; // RL1
                    next_read_hit = 1'b1;
                end
                `ADDR_INSTR_POINTER_HIGH_BYTE: begin
                    next_read_data = instruction_pointer[`IP_HIGH_MSB:`IP_HIGH_LSB]; // RL3
                    next_read_hit = 1'b1;
                end
                `ADDR_INSTR_POINTER_LOW_BYTE: begin
                    next_read_data = instruction_pointer[`IP_LOW_MSB:`IP_LOW_LSB]; // RL4
                    next_read_hit = 1'b1;
                end
                default: begin
                    next_read_data = `BYTE_ZERO;
                    next_read_hit = 1'b0;
                end
            endcase
        end
    end

    // Requests come from outside the core domain, so two stages precede gating.
    always @(posedge clock) begin
        if (rst) begin
            request_meta <= `BYTE_ZERO;
            request_sync <= `BYTE_ZERO;
            recognised_request <= `BYTE_ZERO;
            reg_read_data <= `BYTE_ZERO;
            reg_read_hit <= 1'b0;
        end else if (clock_enable) begin
            request_meta <= interrupt_level_request;
            request_sync <= request_meta;
            recognised_request <= request_sync & interrupt_level_enable; // RL2
            reg_read_data <= next_read_data;
            reg_read_hit <= next_read_hit;
        end
    end

    // Reset leaves these undefined in the device; zero is used so simulation stays clean,
    // but software still must program every bit before use.
    always @(posedge clock) begin
        if (rst) begin
            interrupt_level_enable <= `BYTE_ZERO; // RL6
            instruction_pointer <= {`BYTE_ZERO, `BYTE_ZERO};
        end else if (clock_enable) begin
            if (write_enable) begin
                interrupt_level_enable <= reg_write_data; // RL1
            end
            // A register write beats a core load of the same byte in the same cycle.
            if (write_high) begin
                instruction_pointer[`IP_HIGH_MSB:`IP_HIGH_LSB] <= reg_write_data; // RL3
            end else if (ip_load) begin
                instruction_pointer[`IP_HIGH_MSB:`IP_HIGH_LSB] <= ip_load_value[`IP_HIGH_MSB:`IP_HIGH_LSB];
            end
            if (write_low) begin
                instruction_pointer[`IP_LOW_MSB:`IP_LOW_LSB] <= reg_write_data; // RL4
            end else if (ip_load) begin
                instruction_pointer[`IP_LOW_MSB:`IP_LOW_LSB] <= ip_load_value[`IP_LOW_MSB:`IP_LOW_LSB];
            end
        end
    end

endmodule // interrupt_mask_and_instr_pointer
`default_nettype wire

// ---- shared/intmask_ip_defines.vh ----
// Register addresses and field constants for the interrupt mask and instruction pointer block.
`ifndef INTMASK_IP_DEFINES_VH
`define INTMASK_IP_DEFINES_VH
`define ADDR_INSTR_POINTER_HIGH_BYTE 8'hda
`define ADDR_INSTR_POINTER_LOW_BYTE 8'hdb
`define ADDR_INTERRUPT_LEVEL_ENABLE 8'hdd
`define LEVEL_COUNT 8
`define BYTE_ZERO 8'h00
`define IP_HIGH_MSB 15
`define IP_HIGH_LSB 8
`define IP_LOW_MSB 7
`define IP_LOW_LSB 0
`endif

// ---- tb/core_model.sv ----
// Core model: drives request levels and vectors to a recognised level.
`timescale 1ns/1ps
`default_nettype none
module core_model (input wire logic clock, input wire logic [7:0] raise, recognised_request,
    output var logic ip_load = 1'h0, output var logic [15:0] ip_load_value = 16'h0000,
    output var logic [7:0] interrupt_level_request = 8'h00);
    always @(posedge clock) {interrupt_level_request, ip_load, ip_load_value} <=
        {raise, |recognised_request, 8'h01, recognised_request};
endmodule // core_model
`default_nettype wire

// ---- tb/imip_assertions.sv ----
// Assertions on the mask and pointer block ports.
`timescale 1ns/1ps
`default_nettype none
module imip_chk (input wire logic clock, rst, clock_enable, reg_direct_mode, reg_write, reg_read,
    reg_read_hit, input wire logic [7:0] reg_address, reg_write_data, interrupt_level_enable,
    recognised_request, input wire logic [15:0] instruction_pointer);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire w = clock_enable & reg_write & reg_direct_mode;
    wire [7:0] a = reg_address, d = reg_write_data, m = interrupt_level_enable;
    wire [15:0] p = instruction_pointer;
    AST_EN: assert property (w && a == 8'hdd |=> m == $past(d)) else $error("mask lost");
    AST_HI: assert property (w && a == 8'hda |=> p[15:8] == $past(d)) else $error("high lost");
    AST_LO: assert property (w && a == 8'hdb |=> p[7:0] == $past(d)) else $error("low lost");
    AST_GATE: assert property ($past(clock_enable) |-> !(recognised_request & ~$past(m)))
        else $error("masked level seen");
    AST_RD: assert property (clock_enable && reg_read && !reg_direct_mode |=> !reg_read_hit)
        else $error("indirect read hit");
    cover property (reg_read_hit);
    cover property (recognised_request != 8'h00);
    cover property (w);
endmodule // imip_chk
bind interrupt_mask_and_instr_pointer imip_chk chk (.*);
`default_nettype wire

// ---- tb/interrupt_mask_and_instr_pointer_tb.sv ----
// Bench for the mask and pointer block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(x, y) begin n_compared++; if ((x) !== (y)) begin miscompares++; \
    $display("CHECK FAILED %0t bad value", $time); end end
module interrupt_mask_and_instr_pointer_tb;
    logic clock = 1'h0, rst = 1'h1, clock_enable = 1'h1, reg_direct_mode = 1'h1, reg_write = 1'h0;
    logic reg_read = 1'h0, reg_read_hit, ip_load;
    logic [7:0] reg_address = 8'h00, reg_write_data = 8'h00, raise = 8'h00, reg_read_data;
    logic [7:0] interrupt_level_request, interrupt_level_enable, recognised_request;
    logic [15:0] instruction_pointer, ip_load_value;
    int miscompares = 0, n_compared = 0;
    interrupt_mask_and_instr_pointer interrupt_mask_and_instr_pointer_i (.*);
    core_model core_model_i (.*);
    initial forever #5 clock = ~clock;
    task automatic acc(input logic w, input logic [7:0] a, d, e = 8'h00, input logic h = 1'h0);
        @(posedge clock) {reg_write, reg_read, reg_address, reg_write_data} <= {w, !w, a, d};
        @(posedge clock) {reg_write, reg_read} <= 2'h0;
        #1 if (!w) begin `CHK(reg_read_data, e) `CHK(reg_read_hit, h) end
    endtask
    task automatic reg_scenario;
        acc(1, 8'hdd, 8'h5a); acc(1, 8'hda, 8'hc3); acc(1, 8'hdb, 8'h3c);
        `CHK(instruction_pointer, 16'hc33c)
        acc(0, 8'hda, 8'h00, 8'hc3, 1); acc(0, 8'hdb, 8'h00, 8'h3c, 1);
        @(posedge clock) reg_direct_mode <= 1'h0;
        acc(1, 8'hdd, 8'hff); acc(0, 8'hdd, 8'h00);
        @(posedge clock) reg_direct_mode <= 1'h1;
        acc(0, 8'hdd, 8'h00, 8'h5a, 1); acc(0, 8'hdc, 8'h00);
    endtask
    task automatic mask_scenario;
        @(posedge clock) raise <= 8'hff;
        for (int n = 0; n < 8; n++) begin
            acc(1, 8'hdd, 8'h01 << n);
            repeat (4) @(posedge clock);
            #1 `CHK(recognised_request, 8'h01 << n)
        end
        `CHK(instruction_pointer, 16'h0180)
    endtask
    task automatic enable_scenario;
        @(posedge clock) clock_enable <= 1'h0;
        acc(1, 8'hdd, 8'h0f);
        `CHK(interrupt_level_enable, 8'h80)
        @(posedge clock) clock_enable <= 1'h1;
        acc(0, 8'hdd, 8'h00, 8'h80, 1);
    endtask
    task automatic report_and_stop;
        $display("%0d compared, %0d miscompares", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'h0;
        reg_scenario();
        mask_scenario();
        enable_scenario();
        report_and_stop();
    end
    // The work takes about 80 cycles, so 20 us can only mean a hang.
    initial begin #20us; miscompares++; report_and_stop(); end
endmodule // interrupt_mask_and_instr_pointer_tb
`default_nettype wire
